// ---- src/ovms_pkg.sv ----
package ovms_pkg;
    // host byte link timing, in its own unit
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BAUD_BPS = 9600;
    // cycles per bit, rounded down (10416 at the defaults)
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD_BPS;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int unsigned FIFO_DEPTH = 32;
    // byte codes
    localparam logic [7:0] ESC_BYTE = 8'h1B;
    localparam logic [7:0] LBRK_BYTE = 8'h5B;
    localparam logic [7:0] LF_BYTE = 8'h0A;
    localparam logic [7:0] PRINT_LO = 8'h20;
    localparam logic [7:0] PRINT_HI = 8'h7E;
    localparam logic [7:0] FINAL_LO = 8'h40;
    localparam logic [7:0] FINAL_HI = 8'h7E;
    // video operating modes
    typedef enum logic [1:0] {VM_AUTO, VM_LOCAL, VM_GENLOCK} ovms_vmode_t;
    // token kinds handed to the renderer
    typedef enum logic [2:0] {TK_HOME, TK_PRINT, TK_LF, TK_CMD, TK_CMD_END} ovms_kind_t;
    typedef struct packed {
        ovms_kind_t kind;
        logic [7:0] code;
    } ovms_tok_t;
endpackage

// ---- src/ovms_top.sv ----
`timescale 1ns/10ps
module ovms_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 32
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // full and empty come straight from the fill count
    assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem[rd_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // pointer and count update
    always_comb begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_reg] <= i_in_data;
        end
    end
endmodule

module ovms_top import ovms_pkg::*; #(
    parameter int unsigned BIT_CYC_P = BIT_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // host serial link
    input wire logic i_rxd,
    output logic o_link_ready,
    output logic o_rx_err,
    // video mode control
    input wire logic i_mode_load,
    input wire ovms_vmode_t i_mode_sel,
    input wire logic i_video_present,
    input wire logic i_frame_tick,
    output ovms_vmode_t o_mode,
    output logic o_genlock,
    // token stream to renderer
    output logic o_tok_valid,
    input wire logic i_tok_ready,
    output ovms_tok_t o_tok
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ovms_rx_t;
    typedef enum logic [1:0] {PS_HOME, PS_TEXT, PS_ESC, PS_CMD} ovms_ps_t;

    function automatic logic is_text(input logic [7:0] b);
        is_text = (b == LF_BYTE) || (b >= PRINT_LO && b <= PRINT_HI);
    endfunction

    function automatic ovms_tok_t text_tok(input logic [7:0] b);
        text_tok.kind = (b == LF_BYTE) ? TK_LF : TK_PRINT;
        text_tok.code = b;
    endfunction

    // pin synchronisers
    logic rx_s1_reg, rx_s2_reg, vid_s1_reg, vid_s2_reg;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            vid_s1_reg <= 1'b0;
            vid_s2_reg <= 1'b0;
        end else begin
            rx_s1_reg <= i_rxd;
            rx_s2_reg <= rx_s1_reg;
            vid_s1_reg <= i_video_present;
            vid_s2_reg <= vid_s1_reg;
        end
    end

    // serial receiver, sampling each bit at its middle
    ovms_rx_t rx_st_reg, rx_st_next;
    logic [CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
    logic [2:0] rx_bit_reg, rx_bit_next;
    logic [7:0] rx_sh_reg, rx_sh_next;
    logic rx_push_reg, rx_push_next, rx_err_reg, rx_err_next;
    logic f_in_ready, f_valid, take;
    logic [7:0] f_data;
    logic link_rdy_reg;

    always_comb begin
        rx_st_next = rx_st_reg;
        rx_cnt_next = rx_cnt_reg - 1'b1;
        rx_bit_next = rx_bit_reg;
        rx_sh_next = rx_sh_reg;
        rx_push_next = 1'b0;
        rx_err_next = rx_err_reg;
        case (rx_st_reg)
            RX_IDLE: begin
                rx_cnt_next = CNT_W'(BIT_CYC_P / 2);
                if (!rx_s2_reg) begin
                    rx_st_next = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt_reg == '0) begin
                    rx_cnt_next = CNT_W'(BIT_CYC_P - 1);
                    rx_bit_next = '0;
                    // a start bit gone high by mid-bit was a glitch
                    rx_st_next = rx_s2_reg ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_cnt_reg == '0) begin
                    rx_cnt_next = CNT_W'(BIT_CYC_P - 1);
                    rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]}; // lsb first
                    rx_bit_next = rx_bit_reg + 1'b1;
                    if (rx_bit_reg == LAST_BIT) begin
                        rx_st_next = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_cnt_reg == '0) begin
                    rx_st_next = RX_IDLE;
                    // one stop bit, no parity; bad stop or full buffer drops byte
                    if (!rx_s2_reg || !f_in_ready) begin
                        rx_err_next = 1'b1;
                    end else begin
                        rx_push_next = 1'b1;
                    end
                end
            end
            default: rx_st_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_st_reg <= RX_IDLE;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_sh_reg <= '0;
            rx_push_reg <= 1'b0;
            rx_err_reg <= 1'b0;
            link_rdy_reg <= 1'b0;
        end else begin
            rx_st_reg <= rx_st_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bit_reg <= rx_bit_next;
            rx_sh_reg <= rx_sh_next;
            rx_push_reg <= rx_push_next;
            rx_err_reg <= rx_err_next;
            link_rdy_reg <= f_in_ready;
        end
    end

    // buffer between the link and the parser; a stalled renderer fills it
    ovms_fifo #(.W(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_in_valid(rx_push_reg),
        .o_in_ready(f_in_ready),
        .i_in_data(rx_sh_reg),
        .o_out_valid(f_valid),
        .i_out_ready(take),
        .o_out_data(f_data)
    );

    // byte parser: text, line feed and escape sequences
    ovms_ps_t ps_reg, ps_next;
    ovms_tok_t tok_reg, tok_next;
    logic tv_reg, tv_next, slot_free;

    assign slot_free = !tv_reg || i_tok_ready;
    assign take = f_valid && slot_free && (ps_reg != PS_HOME);

    always_comb begin
        ps_next = ps_reg;
        tok_next = tok_reg;
        tv_next = tv_reg && !i_tok_ready;
        case (ps_reg)
            PS_HOME: begin
                // cursor to upper-left before the first character
                if (slot_free) begin
                    tok_next = '{kind: TK_HOME, code: '0};
                    tv_next = 1'b1;
                    ps_next = PS_TEXT;
                end
            end
            PS_TEXT: begin
                if (take) begin
                    if (f_data == ESC_BYTE) begin
                        ps_next = PS_ESC;
                    end else if (is_text(f_data)) begin
                        tok_next = text_tok(f_data);
                        tv_next = 1'b1;
                    end
                end
            end
            PS_ESC: begin
                if (take) begin
                    if (f_data == LBRK_BYTE) begin
                        ps_next = PS_CMD;
                    end else if (f_data != ESC_BYTE) begin
                        // a lone escape is dropped; the byte counts as text
                        ps_next = PS_TEXT;
                        if (is_text(f_data)) begin
                            tok_next = text_tok(f_data);
                            tv_next = 1'b1;
                        end
                    end
                end
            end
            PS_CMD: begin
                // command bytes go to the executor, never to the screen
                if (take) begin
                    tv_next = 1'b1;
                    tok_next.code = f_data;
                    if (f_data >= FINAL_LO && f_data <= FINAL_HI) begin
                        tok_next.kind = TK_CMD_END;
                        ps_next = PS_TEXT;
                    end else begin
                        tok_next.kind = TK_CMD;
                    end
                end
            end
            default: ps_next = PS_HOME;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ps_reg <= PS_HOME;
            tok_reg <= '{kind: TK_HOME, code: '0};
            tv_reg <= 1'b0;
        end else begin
            ps_reg <= ps_next;
            tok_reg <= tok_next;
            tv_reg <= tv_next;
        end
    end

    // video mode; mode loads at once, genlock switching is held to frame ticks so no field is torn
    ovms_vmode_t mode_reg, mode_next;
    logic gl_reg, gl_next, want_gl;

    always_comb begin
        mode_next = i_mode_load ? i_mode_sel : mode_reg;
        case (mode_reg)
            VM_LOCAL: want_gl = 1'b0;
            VM_GENLOCK: want_gl = 1'b1; // dropouts ignored
            default: want_gl = vid_s2_reg;
        endcase
        gl_next = i_frame_tick ? want_gl : gl_reg;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_reg <= VM_AUTO;
            gl_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            gl_reg <= gl_next;
        end
    end

    assign o_link_ready = link_rdy_reg;
    assign o_rx_err = rx_err_reg;
    assign o_mode = mode_reg;
    assign o_genlock = gl_reg;
    assign o_tok_valid = tv_reg;
    assign o_tok = tok_reg;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    property p_auto_at_start;
        !$past(i_reset_n) |-> mode_reg == VM_AUTO && !gl_reg;
    endproperty
    a_auto_at_start: assert property (p_auto_at_start)
        else $error("mode not automatic after reset");

    property p_auto_local;
        i_frame_tick && mode_reg == VM_AUTO && !vid_s2_reg |=> !gl_reg;
    endproperty
    a_auto_local: assert property (p_auto_local)
        else $error("auto without video did not pick local");

    property p_auto_genlock;
        i_frame_tick && mode_reg == VM_AUTO && vid_s2_reg |=> gl_reg;
    endproperty
    a_auto_genlock: assert property (p_auto_genlock)
        else $error("auto with video did not pick genlock");

    property p_force_local;
        i_frame_tick && mode_reg == VM_LOCAL |=> !gl_reg;
    endproperty
    a_force_local: assert property (p_force_local)
        else $error("forced local left local");

    property p_force_genlock;
        mode_reg == VM_GENLOCK && gl_reg && !i_mode_load |=> gl_reg;
    endproperty
    a_force_genlock: assert property (p_force_genlock)
        else $error("forced genlock fell back");

    property p_frame_only;
        !i_frame_tick |=> $stable(gl_reg);
    endproperty
    a_frame_only: assert property (p_frame_only)
        else $error("mode changed off a frame boundary");

    property p_csi;
        ps_reg == PS_ESC && take && f_data == LBRK_BYTE |=> ps_reg == PS_CMD;
    endproperty
    a_csi: assert property (p_csi)
        else $error("introducer not recognised");

    property p_lf;
        ps_reg == PS_TEXT && take && f_data == LF_BYTE
            |=> tv_reg && tok_reg.kind == TK_LF;
    endproperty
    a_lf: assert property (p_lf)
        else $error("line feed not decoded");

    property p_no_print_esc;
        tv_reg && tok_reg.kind == TK_PRINT
            |-> tok_reg.code >= PRINT_LO && tok_reg.code <= PRINT_HI;
    endproperty
    a_no_print_esc: assert property (p_no_print_esc)
        else $error("non-printable byte printed");

    property p_stop_bit;
        rx_st_reg == RX_STOP && rx_cnt_reg == '0 && !rx_s2_reg |=> !rx_push_reg;
    endproperty
    a_stop_bit: assert property (p_stop_bit)
        else $error("byte with bad stop bit accepted");
endmodule

// ---- verif/ovms_host_model.sv ----
`timescale 1ns/10ps
module ovms_host_model #(
    parameter int unsigned BIT_CYC_P = 16
) (
    // clock
    input wire logic i_core_clk,
    // flow control from the device
    input wire logic i_link_ready,
    // serial line into the device
    output logic o_rxd
);
    // line idles high from time zero, as a real uart does
    initial o_rxd = 1'h1;

    // one frame; obey low ignores flow control so an overflow can be provoked
    task automatic send(input logic [7:0] b, input logic stop_ok, input logic obey);
        logic [9:0] frame;
        int n;
        frame = {stop_ok, b, 1'h0}; // start low, lsb first, no parity, one stop
        n = 0;
        while (obey && !i_link_ready && n < 20000) begin
            @(negedge i_core_clk);
            n++;
        end
        for (int i = 0; i < 10; i++) begin
            @(negedge i_core_clk);
            o_rxd = frame[i];
            // bit time is a parameter so the run stays short
            repeat (BIT_CYC_P - 1) @(negedge i_core_clk);
        end
        @(negedge i_core_clk);
        o_rxd = 1'h1;
    endtask
endmodule

// ---- verif/ovms_top_tb.sv ----
`timescale 1ns/10ps
module ovms_top_tb import ovms_pkg::*;;
    localparam int unsigned BC = 16;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic mode_load = 1'h0;
    logic video = 1'h0;
    logic tick = 1'h0;
    logic tok_ready = 1'h0;
    logic rdy_rand = 1'h1;
    logic arm = 1'h0;
    logic saw_full = 1'h0;
    logic link_ready, rx_err, genlock, tok_valid, rxd;
    ovms_vmode_t mode_sel = VM_AUTO;
    ovms_vmode_t mode;
    ovms_tok_t tok;
    ovms_tok_t got[$];
    ovms_tok_t exp_q[$];
    logic [7:0] sent[40];
    logic [7:0] corner[6] = '{8'h0A, 8'h01, 8'h7F, 8'h80, 8'h20, 8'h7E};
    int err_total = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    ovms_top #(.BIT_CYC_P(BC)) dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_rxd(rxd), .o_link_ready(link_ready),
        .o_rx_err(rx_err), .i_mode_load(mode_load), .i_mode_sel(mode_sel),
        .i_video_present(video), .i_frame_tick(tick), .o_mode(mode), .o_genlock(genlock),
        .o_tok_valid(tok_valid), .i_tok_ready(tok_ready), .o_tok(tok)
    );
    ovms_host_model #(.BIT_CYC_P(BC)) host (
        .i_core_clk(clk), .i_link_ready(link_ready), .o_rxd(rxd)
    );

    // renderer stalls at random so tokens must hold until taken
    always @(negedge clk) tok_ready <= rdy_rand ? ($urandom_range(0, 3) != 0) : 1'h0;
    // collect taken tokens and note when the buffer reports full
    always @(posedge clk) begin
        if (rst_n && tok_valid && tok_ready) got.push_back(tok);
        if (arm && !link_ready) saw_full <= 1'h1;
    end

    task automatic fail(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk_tok(input ovms_kind_t k, input logic [7:0] c);
        ovms_tok_t t;
        int n;
        n = 0;
        while (got.size() == 0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        n_tests++;
        if (got.size() == 0) begin
            fail("no token");
        end else begin
            t = got.pop_front();
            if (t.kind !== k || t.code !== c) fail($sformatf("token %h want %h %h", t, k, c));
        end
    endtask

    task automatic chk_mode(input ovms_vmode_t m, input logic g);
        n_tests++;
        if (mode !== m || genlock !== g) begin
            fail($sformatf("mode %0d/%b want %0d/%b", mode, genlock, m, g));
        end
    endtask

    task automatic chk_flag(input logic a, input logic e, input string m);
        n_tests++;
        if (a !== e) fail(m);
    endtask

    // genlock output must stay put until the frame tick, then follow the selection
    task automatic mode_step(input logic ld, input ovms_vmode_t s, input logic v,
                             input ovms_vmode_t em, input logic pre, input logic eg);
        @(negedge clk);
        mode_load = ld;
        mode_sel = s;
        video = v;
        @(negedge clk);
        mode_load = 1'h0;
        repeat (4) @(negedge clk);
        chk_mode(em, pre);
        tick = 1'h1;
        @(negedge clk);
        tick = 1'h0;
        @(negedge clk);
        chk_mode(em, eg);
    endtask

    // expectation per text byte: printable prints, line feed is a control, rest dropped
    function automatic logic shown(input logic [7:0] b);
        return (b == LF_BYTE) || (b >= PRINT_LO && b <= PRINT_HI);
    endfunction

    task automatic send_txt(input logic [7:0] b);
        host.send(b, 1'h1, 1'h1);
        if (shown(b)) exp_q.push_back(ovms_tok_t'{(b == LF_BYTE) ? TK_LF : TK_PRINT, b});
    endtask

    task automatic drain;
        ovms_tok_t t;
        while (exp_q.size() != 0) begin
            t = exp_q.pop_front();
            chk_tok(t.kind, t.code);
        end
    endtask

    task automatic do_reset;
        @(negedge clk);
        rst_n = 1'h0;
        arm = 1'h0;
        got.delete();
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // watchdog sized well above the roughly 22k cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        fail("watchdog");
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hA0D8FFF8));
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        chk_mode(VM_AUTO, 1'h0);
        chk_tok(TK_HOME, 8'h00);
        $display("test reset done");
        mode_step(1'h0, VM_AUTO, 1'h0, VM_AUTO, 1'h0, 1'h0);
        mode_step(1'h0, VM_AUTO, 1'h1, VM_AUTO, 1'h0, 1'h1);
        mode_step(1'h0, VM_AUTO, 1'h0, VM_AUTO, 1'h1, 1'h0);
        mode_step(1'h1, VM_LOCAL, 1'h1, VM_LOCAL, 1'h0, 1'h0);
        mode_step(1'h1, VM_GENLOCK, 1'h0, VM_GENLOCK, 1'h0, 1'h1);
        mode_step(1'h0, VM_GENLOCK, 1'h1, VM_GENLOCK, 1'h1, 1'h1);
        mode_step(1'h0, VM_GENLOCK, 1'h0, VM_GENLOCK, 1'h1, 1'h1);
        mode_step(1'h1, VM_AUTO, 1'h0, VM_AUTO, 1'h1, 1'h0);
        // the spare select code behaves as automatic
        mode_step(1'h1, ovms_vmode_t'(2'h3), 1'h1, ovms_vmode_t'(2'h3), 1'h0, 1'h1);
        mode_step(1'h1, VM_AUTO, 1'h0, VM_AUTO, 1'h1, 1'h0);
        $display("test video mode done");
        foreach (corner[i]) send_txt(corner[i]);
        for (int i = 0; i < 20; i++) send_txt(8'($urandom_range(32, 126)));
        drain();
        $display("test text done");
        host.send(ESC_BYTE, 1'h1, 1'h1);
        host.send(LBRK_BYTE, 1'h1, 1'h1);
        host.send(8'h31, 1'h1, 1'h1);
        host.send(8'h48, 1'h1, 1'h1);
        send_txt(8'h41);
        // lone escapes are dropped and the next byte prints as text
        host.send(ESC_BYTE, 1'h1, 1'h1);
        host.send(ESC_BYTE, 1'h1, 1'h1);
        send_txt(8'h43);
        chk_tok(TK_CMD, 8'h31);
        chk_tok(TK_CMD_END, 8'h48);
        drain();
        $display("test command done");
        host.send(8'h55, 1'h0, 1'h1);
        repeat (4 * BC) @(negedge clk);
        chk_flag(rx_err, 1'h1, "bad stop not flagged");
        send_txt(8'h42);
        drain();
        $display("test framing done");
        do_reset();
        chk_flag(rx_err, 1'h0, "error survived reset");
        chk_tok(TK_HOME, 8'h00);
        // renderer stalls long enough that the sender must obey flow control
        rdy_rand = 1'h0;
        arm = 1'h1;
        fork
            for (int i = 0; i < 48; i++) send_txt(8'($urandom_range(32, 126)));
            begin
                repeat (7000) @(negedge clk);
                rdy_rand = 1'h1;
            end
        join
        drain();
        chk_flag(saw_full, 1'h1, "buffer never full");
        chk_flag(rx_err, 1'h0, "loss under flow control");
        $display("test fill done");
        // sender ignores flow control: 33 survive, one in the token slot and 32 buffered
        rdy_rand = 1'h0;
        for (int i = 0; i < 40; i++) begin
            sent[i] = 8'($urandom_range(32, 126));
            host.send(sent[i], 1'h1, 1'h0);
        end
        repeat (2 * BC) @(negedge clk);
        chk_flag(rx_err, 1'h1, "overflow not flagged");
        rdy_rand = 1'h1;
        for (int i = 0; i < 33; i++) chk_tok(TK_PRINT, sent[i]);
        repeat (500) @(negedge clk);
        chk_flag(got.size() == 0, 1'h1, "dropped byte delivered");
        $display("test overflow done");
        tally_and_finish();
    end
endmodule
